// ### interrupt_flag_regs.sv
// Purpose: pending-interrupt flag register, enable mask and interrupt output
// Assumes: register requests come from the serial host port logic on core_clk
// Notes: write zero to a flag bit to request its clear; ones are ignored
//
// Contract
// - eight-bit flag register, message error at bit 7 down to receive flags.
// - receive buffer 1 and 0 full flags set when a message lands there.
// - a set flag stays set until the host clears it; zero means idle.
// - error summary flag set by any new error-condition register source.
// - flag register sits at register address 2C hex.
// - interrupt request stays pending while any flag remains set.
// - host clear fails while the underlying interrupt condition still holds.
// - active-low interrupt pin driven when a flag and its enable are set.
`timescale 1ns/1ns
`default_nettype none
module interrupt_flag_regs
    import intf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire reg_req_t reg_req,
    input wire event_pulses_t event_pulses,
    input wire flag_bits_t condition_active,
    input wire logic [ERROR_CONDITION_WIDTH-1:0] error_condition_register,
    output logic [7:0] reg_rdata_ff,
    output logic reg_rvalid_ff,
    output logic int_n_ff,
    output logic irq_pending_ff
);
    // ****************************************
    // flag bits
    // ****************************************
    logic [FLAG_COUNT-1:0] set_vec;
    logic [FLAG_COUNT-1:0] clear_vec;
    logic [FLAG_COUNT-1:0] flags;
    logic [ERROR_CONDITION_WIDTH-1:0] error_seen_ff;
    logic [7:0] interrupt_enable_mask_ff;
    logic error_rise;
    logic flag_write;

    // a rising error condition bit counts as one event; level sources would re-set forever
    assign error_rise = |(error_condition_register & ~error_seen_ff);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            error_seen_ff <= '0;
        end else begin
            error_seen_ff <= error_condition_register;
        end
    end

    assign flag_write = reg_req.wr_en && (reg_req.addr == ADDR_INTERRUPT_PENDING_FLAGS);

    always_comb begin
        set_vec = '0;
        set_vec[BIT_MESSAGE_ERROR] = event_pulses.message_error;
        set_vec[BIT_BUS_WAKEUP] = event_pulses.bus_wakeup;
        set_vec[BIT_ERROR_SUMMARY] = error_rise;
        set_vec[BIT_TX_BUFFER2_EMPTY] = event_pulses.tx_buffer2_empty;
        set_vec[BIT_TX_BUFFER1_EMPTY] = event_pulses.tx_buffer1_empty;
        set_vec[BIT_TX_BUFFER0_EMPTY] = event_pulses.tx_buffer0_empty;
        set_vec[BIT_RX_BUFFER1_FULL] = event_pulses.rx_buffer1_full;
        set_vec[BIT_RX_BUFFER0_FULL] = event_pulses.rx_buffer0_full;
        clear_vec = flag_write ? ~reg_req.wdata : '0;
    end

    genvar gi;
    generate
        for (gi = 0; gi < FLAG_COUNT; gi++) begin : g_flag
            pending_flag_bit u_bit (
                .core_clk(core_clk),
                .rst(rst),
                .set_event(set_vec[gi]),
                .condition_active(condition_active[gi]),
                .clear_req(clear_vec[gi]),
                .flag_ff(flags[gi])
            );
        end
    endgenerate

    // ****************************************
    // enable mask and read port
    // ****************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            interrupt_enable_mask_ff <= RESET_INTERRUPT_ENABLE_MASK;
        end else if (reg_req.wr_en && reg_req.addr == ADDR_INTERRUPT_ENABLE_MASK) begin
            interrupt_enable_mask_ff <= reg_req.wdata;
        end
    end

    // unmapped addresses read as zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_ff <= 8'h00;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_req.rd_en;
            if (!reg_req.rd_en) begin
                reg_rdata_ff <= 8'h00;
            end else if (reg_req.addr == ADDR_INTERRUPT_PENDING_FLAGS) begin
                reg_rdata_ff <= flags;
            end else if (reg_req.addr == ADDR_INTERRUPT_ENABLE_MASK) begin
                reg_rdata_ff <= interrupt_enable_mask_ff;
            end else begin
                reg_rdata_ff <= 8'h00;
            end
        end
    end

    // ****************************************
    // interrupt outputs
    // ****************************************
    // registered output costs one cycle of latency but keeps the pin glitch free
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            int_n_ff <= 1'b1;
            irq_pending_ff <= 1'b0;
        end else begin
            int_n_ff <= ~|(flags & interrupt_enable_mask_ff);
            irq_pending_ff <= |flags;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_flag_write_clear(int b);
        flag_write && !reg_req.wdata[b] && !condition_active[b] && !set_vec[b];
    endsequence

    sequence s_flag_read;
        reg_req.rd_en && (reg_req.addr == ADDR_INTERRUPT_PENDING_FLAGS);
    endsequence

    sequence s_mask_write;
        reg_req.wr_en && (reg_req.addr == ADDR_INTERRUPT_ENABLE_MASK);
    endsequence

    AST_RX0_SETS: assert property (@(posedge core_clk) disable iff (rst)
        event_pulses.rx_buffer0_full |=> flags[BIT_RX_BUFFER0_FULL])
        else $error("receive buffer 0 flag not set");
    AST_RX1_SETS: assert property (@(posedge core_clk) disable iff (rst)
        event_pulses.rx_buffer1_full |=> flags[BIT_RX_BUFFER1_FULL])
        else $error("receive buffer 1 flag not set");
    AST_MSGERR_POS: assert property (@(posedge core_clk) disable iff (rst)
        event_pulses.message_error |=> flags[7])
        else $error("message error flag not at bit 7");
    AST_STICKY: assert property (@(posedge core_clk) disable iff (rst)
        (flags[BIT_TX_BUFFER0_EMPTY] && !clear_vec[BIT_TX_BUFFER0_EMPTY]) |=> flags[BIT_TX_BUFFER0_EMPTY])
        else $error("flag dropped without clear");
    AST_CLEAR_WORKS: assert property (@(posedge core_clk) disable iff (rst)
        s_flag_write_clear(BIT_TX_BUFFER1_EMPTY) |=> !flags[BIT_TX_BUFFER1_EMPTY])
        else $error("host clear ignored");
    AST_ERRSUM: assert property (@(posedge core_clk) disable iff (rst)
        (|(error_condition_register & ~error_seen_ff)) |=> flags[BIT_ERROR_SUMMARY])
        else $error("error summary not set by new error condition");
    AST_CLEAR_BLOCKED: assert property (@(posedge core_clk) disable iff (rst)
        (flags[BIT_BUS_WAKEUP] && condition_active[BIT_BUS_WAKEUP]) |=> flags[BIT_BUS_WAKEUP])
        else $error("flag cleared while condition active");
    AST_PENDING: assert property (@(posedge core_clk) disable iff (rst)
        (|flags) |=> irq_pending_ff)
        else $error("pending request missing");
    AST_INT_PIN: assert property (@(posedge core_clk) disable iff (rst)
        ##1 (int_n_ff == !$past(|(flags & interrupt_enable_mask_ff))))
        else $error("interrupt pin does not follow enabled flags");
    AST_RESET_ZERO: assert property (@(posedge core_clk)
        $fell(rst) |-> (flags == RESET_INTERRUPT_PENDING_FLAGS))
        else $error("flags not zero after reset");

    // ****************************************
    // per-bit set and quiet checks
    // ****************************************
    // quiet checks catch a flag that sets with no cause, which a set-only check never sees
    AST_WAKE_SETS: assert property (@(posedge core_clk) disable iff (rst)
        event_pulses.bus_wakeup |=> flags[BIT_BUS_WAKEUP])
        else $error("bus wake-up flag not set");
    AST_TX2_SETS: assert property (@(posedge core_clk) disable iff (rst)
        event_pulses.tx_buffer2_empty |=> flags[BIT_TX_BUFFER2_EMPTY])
        else $error("transmit buffer 2 flag not set");
    AST_TX1_SETS: assert property (@(posedge core_clk) disable iff (rst)
        event_pulses.tx_buffer1_empty |=> flags[BIT_TX_BUFFER1_EMPTY])
        else $error("transmit buffer 1 flag not set");
    AST_TX0_SETS: assert property (@(posedge core_clk) disable iff (rst)
        event_pulses.tx_buffer0_empty |=> flags[BIT_TX_BUFFER0_EMPTY])
        else $error("transmit buffer 0 flag not set");
    AST_MSGERR_QUIET: assert property (@(posedge core_clk) disable iff (rst)
        (!flags[BIT_MESSAGE_ERROR] && !event_pulses.message_error) |=> !flags[BIT_MESSAGE_ERROR])
        else $error("message error flag set with no event");
    AST_TX2_QUIET: assert property (@(posedge core_clk) disable iff (rst)
        (!flags[BIT_TX_BUFFER2_EMPTY] && !event_pulses.tx_buffer2_empty) |=> !flags[BIT_TX_BUFFER2_EMPTY])
        else $error("transmit buffer 2 flag set with no event");
    AST_RX0_QUIET: assert property (@(posedge core_clk) disable iff (rst)
        (!flags[BIT_RX_BUFFER0_FULL] && !event_pulses.rx_buffer0_full) |=> !flags[BIT_RX_BUFFER0_FULL])
        else $error("receive buffer 0 flag set with no message");
    AST_RX1_QUIET: assert property (@(posedge core_clk) disable iff (rst)
        (!flags[BIT_RX_BUFFER1_FULL] && !event_pulses.rx_buffer1_full) |=> !flags[BIT_RX_BUFFER1_FULL])
        else $error("receive buffer 1 flag set with no message");
    AST_NO_DROP: assert property (@(posedge core_clk) disable iff (rst)
        !flag_write |=> ((flags & $past(flags)) == $past(flags)))
        else $error("flag dropped with no host write");
    AST_CLEAR_ALL: assert property (@(posedge core_clk) disable iff (rst)
        (flag_write && (reg_req.wdata == 8'h00) && (condition_active == 8'h00) && (set_vec == 8'h00))
        |=> (flags == 8'h00))
        else $error("host clear of all flags ignored");
    AST_ERRSUM_QUIET: assert property (@(posedge core_clk) disable iff (rst)
        (!flags[BIT_ERROR_SUMMARY] && !error_rise) |=> !flags[BIT_ERROR_SUMMARY])
        else $error("error summary set with no new error condition");

    // ****************************************
    // read port, pending and pin checks
    // ****************************************
    AST_READ_FLAGS: assert property (@(posedge core_clk) disable iff (rst)
        s_flag_read |=> (reg_rvalid_ff && (reg_rdata_ff == $past(flags))))
        else $error("flag read returned wrong data");
    AST_READ_IDLE: assert property (@(posedge core_clk) disable iff (rst)
        !reg_req.rd_en |=> (!reg_rvalid_ff && (reg_rdata_ff == 8'h00)))
        else $error("read answer without a read");
    AST_UNMAPPED_READ: assert property (@(posedge core_clk) disable iff (rst)
        (reg_req.rd_en && (reg_req.addr != ADDR_INTERRUPT_PENDING_FLAGS)
            && (reg_req.addr != ADDR_INTERRUPT_ENABLE_MASK)) |=> (reg_rdata_ff == 8'h00))
        else $error("unmapped read not zero");
    AST_NOT_PENDING: assert property (@(posedge core_clk) disable iff (rst)
        (flags == 8'h00) |=> !irq_pending_ff)
        else $error("pending request with no flag set");
    AST_GATED_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        (|(flags & condition_active)) |=> ((flags & $past(flags & condition_active)) == $past(flags & condition_active)))
        else $error("flag with live condition dropped");
    AST_INT_ACTIVE: assert property (@(posedge core_clk) disable iff (rst)
        (|(flags & interrupt_enable_mask_ff)) |=> !int_n_ff)
        else $error("interrupt pin not driven for enabled flag");
    AST_INT_IDLE: assert property (@(posedge core_clk) disable iff (rst)
        !(|(flags & interrupt_enable_mask_ff)) |=> int_n_ff)
        else $error("interrupt pin driven with no enabled flag");
    AST_MASK_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        s_mask_write |=> (interrupt_enable_mask_ff == $past(reg_req.wdata)))
        else $error("enable mask write lost");
    AST_RESET_OUTS: assert property (@(posedge core_clk)
        $fell(rst) |-> (!irq_pending_ff && int_n_ff && !reg_rvalid_ff))
        else $error("outputs not idle after reset");
endmodule
`default_nettype wire

// ### intf_pkg.sv
// Purpose: constants and carrier types for the interrupt flag register block
// Assumes: one core clock, registers reached over a simple internal register port
// Notes: bit positions follow the flag register layout
package intf_pkg;
    localparam logic [7:0] ADDR_INTERRUPT_ENABLE_MASK = 8'h2B;
    localparam logic [7:0] ADDR_INTERRUPT_PENDING_FLAGS = 8'h2C;
    localparam logic [7:0] RESET_INTERRUPT_PENDING_FLAGS = 8'h00;
    localparam logic [7:0] RESET_INTERRUPT_ENABLE_MASK = 8'h00;
    localparam int BIT_MESSAGE_ERROR = 7;
    localparam int BIT_BUS_WAKEUP = 6;
    localparam int BIT_ERROR_SUMMARY = 5;
    localparam int BIT_TX_BUFFER2_EMPTY = 4;
    localparam int BIT_TX_BUFFER1_EMPTY = 3;
    localparam int BIT_TX_BUFFER0_EMPTY = 2;
    localparam int BIT_RX_BUFFER1_FULL = 1;
    localparam int BIT_RX_BUFFER0_FULL = 0;
    localparam int FLAG_COUNT = 8;
    localparam int ERROR_CONDITION_WIDTH = 8;

    typedef struct packed {
        logic message_error;
        logic bus_wakeup;
        logic tx_buffer2_empty;
        logic tx_buffer1_empty;
        logic tx_buffer0_empty;
        logic rx_buffer1_full;
        logic rx_buffer0_full;
    } event_pulses_t;

    typedef struct packed {
        logic message_error;
        logic bus_wakeup;
        logic error_summary;
        logic tx_buffer2_empty;
        logic tx_buffer1_empty;
        logic tx_buffer0_empty;
        logic rx_buffer1_full;
        logic rx_buffer0_full;
    } flag_bits_t;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

// ### pending_flag_bit.sv
// Purpose: one sticky pending-interrupt flag
// Assumes: event and condition come from the same clock domain
// Notes: set wins over clear; clear refused while the condition persists
`timescale 1ns/1ns
`default_nettype none
module pending_flag_bit (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic set_event,
    input wire logic condition_active,
    input wire logic clear_req,
    output logic flag_ff
);
    logic nxt_flag;

    always_comb begin
        nxt_flag = flag_ff;
        if (clear_req && !condition_active) begin
            nxt_flag = 1'b0;
        end
        if (set_event) begin
            nxt_flag = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end
endmodule
`default_nettype wire

// ### host_model.sv
// Purpose: host side of the register port
// Assumes: one-cycle strobes launched on the falling edge
// Notes: released address and data show inverted values
`timescale 1ns/1ns
`default_nettype none
module host_model import intf_pkg::*; (
    input wire logic core_clk,
    output var reg_req_t reg_req
);
    initial reg_req = '0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_req <= '{wr_en: w, rd_en: ~w, addr: a, wdata: d};
        @(negedge core_clk);
        reg_req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 8'h00);
    endtask
endmodule
`default_nettype wire

// ### tb.sv
// Purpose: self-checking bench for interrupt_flag_regs
// Assumes: host_model drives the register port
// Notes: read results are queued and checked on reg_rvalid_ff
`timescale 1ns/1ns
`default_nettype none
module tb import intf_pkg::*; ;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    wire reg_req_t reg_req;
    event_pulses_t event_pulses = '0;
    flag_bits_t condition_active = '0;
    logic [7:0] error_condition_register = 8'h00;
    logic [7:0] reg_rdata_ff;
    logic reg_rvalid_ff;
    logic int_n_ff;
    logic irq_pending_ff;
    logic [7:0] exp_q[$];
    logic [7:0] flags;
    logic [7:0] mask;
    int miscompares = 0;
    int n_tests = 0;
    always #5 core_clk = ~core_clk;
    host_model host_u (.core_clk(core_clk), .reg_req(reg_req));
    interrupt_flag_regs dut_u (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
        .event_pulses(event_pulses), .condition_active(condition_active),
        .error_condition_register(error_condition_register), .reg_rdata_ff(reg_rdata_ff),
        .reg_rvalid_ff(reg_rvalid_ff), .int_n_ff(int_n_ff), .irq_pending_ff(irq_pending_ff));
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.rd(a);
    endtask
    task automatic ev(input int i);
        @(negedge core_clk);
        event_pulses <= 7'(1 << i);
        @(negedge core_clk);
        event_pulses <= '0;
    endtask
    // a read answer with nothing queued is a mismatch too
    // answers are taken at the falling edge, half a cycle after the flop launched them
    always @(negedge core_clk) begin
        if (reg_rvalid_ff === 1'b1) begin
            if (exp_q.size() == 0) begin
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, reg_rvalid_ff, 1'b0);
                miscompares++;
            end else begin
                chk(reg_rdata_ff, exp_q.pop_front());
            end
        end
    end
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        void'($urandom(14));
        repeat (5) @(negedge core_clk);
        rst <= 1'b0;
        chk({7'h00, int_n_ff}, 8'h01);
        rd(ADDR_INTERRUPT_PENDING_FLAGS, RESET_INTERRUPT_PENDING_FLAGS);
        rd(ADDR_INTERRUPT_ENABLE_MASK, RESET_INTERRUPT_ENABLE_MASK);
        rd(8'h10, 8'h00);
        flags = 8'h00;
        for (int i = 0; i < 7; i++) begin
            ev(i);
            flags[i < 5 ? i : i + 1] = 1'b1;
            rd(ADDR_INTERRUPT_PENDING_FLAGS, flags);
        end
        @(negedge core_clk);
        error_condition_register <= 8'h01 << $urandom_range(7);
        @(negedge core_clk);
        flags[BIT_ERROR_SUMMARY] = 1'b1;
        rd(ADDR_INTERRUPT_PENDING_FLAGS, flags);
        chk({6'h00, irq_pending_ff, int_n_ff}, 8'h03);
        mask = 8'($urandom) | 8'h01;
        host_u.wr(ADDR_INTERRUPT_ENABLE_MASK, mask);
        rd(ADDR_INTERRUPT_ENABLE_MASK, mask);
        chk({7'h00, int_n_ff}, 8'h00);
        // a live condition must hold its flag against a clear
        condition_active <= 8'h41;
        host_u.wr(ADDR_INTERRUPT_PENDING_FLAGS, 8'hBE);
        rd(ADDR_INTERRUPT_PENDING_FLAGS, flags);
        condition_active <= 8'h00;
        host_u.wr(ADDR_INTERRUPT_PENDING_FLAGS, 8'hFE);
        rd(ADDR_INTERRUPT_PENDING_FLAGS, 8'hFE);
        host_u.wr(ADDR_INTERRUPT_PENDING_FLAGS, 8'h00);
        rd(ADDR_INTERRUPT_PENDING_FLAGS, 8'h00);
        chk({6'h00, irq_pending_ff, int_n_ff}, 8'h01);
        for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge core_clk);
        if (exp_q.size() > 0) miscompares++;
        print_verdict();
    end
endmodule
`default_nettype wire
